// [logic/tmsc_pkg.sv]
// tmsc_pkg: register map, field positions and reset values of the timer
// synchronise and mode control block.
// assumes a 32-bit APB slave with an 8-bit byte address.
`default_nettype none
package tmsc_pkg;

    localparam int NUM_CH = 5;       // timer channels
    localparam int CNT_W = 16;       // counter width
    localparam int ADDR_W = 8;       // apb byte address width

    // register byte offsets
    localparam logic [7:0] OFS_SYNC = 8'h00;    // channel_sync_select
    localparam logic [7:0] OFS_MODE = 8'h04;    // timer_mode_select
    localparam logic [7:0] OFS_COMBO = 8'h08;   // combination mode field
    localparam logic [7:0] OFS_START = 8'h0C;   // per-channel count start
    localparam logic [7:0] OFS_STATUS = 8'h10;  // sticky overflow flags, ro
    localparam logic [7:0] OFS_CLEAR = 8'h14;   // flag clear, wo
    localparam logic [7:0] OFS_IRQEN = 8'h18;   // flag interrupt enable
    localparam logic [7:0] OFS_CLRA = 8'h1C;    // clear on match a, per ch
    localparam logic [7:0] OFS_CLRB = 8'h20;    // clear on match b, per ch
    localparam logic [7:0] OFS_CH_BASE = 8'h40; // first channel window
    localparam logic [3:0] CH_BASE_IDX = 4'h4;  // OFS_CH_BASE >> 4
    // word index inside a 16-byte channel window
    localparam logic [1:0] CH_CNT = 2'h0;       // channel_counter
    localparam logic [1:0] CH_CMPA = 2'h1;      // general_reg_a
    localparam logic [1:0] CH_CMPB = 2'h2;      // general_reg_b

    // channel_sync_select layout
    localparam logic [7:0] SYNC_RST = 8'h60;    // bit 7 reads as 0
    localparam logic [7:0] SYNC_FIXED = 8'h60;  // bits 6:5 fixed at 1
    // timer_mode_select layout
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam int PHASE_BIT = 6;               // phase_count_select
    localparam int FLAG_DIR_BIT = 5;            // overflow_flag_direction
    // combination mode field
    localparam logic [1:0] COMBO_RST = 2'h0;
    localparam int COMBO_PWM_BIT = 1;           // codes 10 and 11
    localparam int PHASE_CH = 2;                // channel with phase count

    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

endpackage : tmsc_pkg
`default_nettype wire

// [logic/tmsc_phase_dec.sv]
// tmsc_phase_dec: two-phase quadrature decoder for the channel 2 counter.
// assumes the two count inputs are asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module tmsc_phase_dec (
    input wire logic clk,       // peripheral clock
    input wire logic sys_rst,   // synchronous reset, active high
    input wire logic inA,       // ext_count_in_a pin
    input wire logic inB,       // ext_count_in_b pin
    output logic step,          // one-cycle count step
    output logic down           // step direction, 1 = decrement
);
    logic [2:0] aQ;
    logic [2:0] bQ;
    logic aRise, aFall, bRise, bFall;

    // two-flop synchronisers, third stage only for edge detection
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            aQ <= 3'h0;
            bQ <= 3'h0;
        end
        else
        begin
            aQ <= {aQ[1:0], inA};
            bQ <= {bQ[1:0], inB};
        end
    end

    // edges seen on synchronised levels only
    assign aRise = aQ[1] & ~aQ[2];
    assign aFall = ~aQ[1] & aQ[2];
    assign bRise = bQ[1] & ~bQ[2];
    assign bFall = ~bQ[1] & bQ[2];

    // one step per edge; both inputs moving at once is not a valid step
    assign step = (aQ[1] ^ aQ[2]) ^ (bQ[1] ^ bQ[2]);
    assign down = (aRise & ~bQ[1]) | (bRise & aQ[1])
                | (aFall & bQ[1]) | (bFall & ~aQ[1]);

    chk_step_single_edge: assert property (@(posedge clk) disable iff (sys_rst)
        step |=> !step || $changed(aQ[1]) || $changed(bQ[1]))
        else $error("step repeated without a new edge");

endmodule : tmsc_phase_dec
`default_nettype wire

// [logic/tmsc_top.sv]
// tmsc_top: channel synchronise / mode select registers with five 16-bit
// counters, compare registers, pwm pins and overflow interrupt.
// assumes an APB master on clk and standby entry from logic on clk.
`timescale 1ns/1ps
`default_nettype none
module tmsc_top (
    input wire logic clk,                               // 250 MHz clock
    input wire logic sys_rst,                           // sync reset
    input wire logic standbyEnter,                      // standby entry
    input wire logic [tmsc_pkg::ADDR_W-1:0] paddr,      // apb address
    input wire logic psel,                              // apb select
    input wire logic penable,                           // apb enable
    input wire logic pwrite,                            // apb direction
    input wire logic [31:0] pwdata,                     // apb write data
    output logic [31:0] prdata,                         // apb read data
    output logic pready,                                // apb ready
    output logic pslverr,                               // apb error
    input wire logic extCountInA,                       // phase input a
    input wire logic extCountInB,                       // phase input b
    output logic [tmsc_pkg::NUM_CH-1:0] ioPinAOut,      // pin a level
    output logic [tmsc_pkg::NUM_CH-1:0] ioPinAOe,       // pin a drive
    output logic irq                                    // level interrupt
);
    import tmsc_pkg::*;

    logic [4:0] syncQ;
    logic [6:0] modeQ;
    logic [1:0] comboQ;
    logic [4:0] startQ, clrAQ, clrBQ, statusQ, irqEnQ, pinQ;
    logic [CNT_W-1:0] cntQ [NUM_CH];
    logic [CNT_W-1:0] cntD [NUM_CH];
    logic [CNT_W-1:0] cmpAQ [NUM_CH];
    logic [CNT_W-1:0] cmpBQ [NUM_CH];
    logic [4:0] stepV, downV, wrapUpV, unfV, matchA, matchB, clrEv, flagEv;
    logic [4:0] pwmEff, pwmSetV;
    logic qStep, qDown, wrEn, wrCnt, syncWrHit, syncClr;
    logic [3:0] wrCh;
    logic [31:0] rdVal;

    // channel index of a per-channel window address
    function automatic logic [3:0] chOf(input logic [7:0] a);
        return 4'(a[7:4] - CH_BASE_IDX);
    endfunction : chOf

    // address lies inside a channel window on a used word
    function automatic logic isCh(input logic [7:0] a);
        return a >= OFS_CH_BASE && chOf(a) < 4'(NUM_CH)
            && a[3:2] != 2'h3 && a[1:0] == 2'h0;
    endfunction : isCh

    function automatic logic mapped(input logic [7:0] a);
        return isCh(a) || (a <= OFS_CLRB && a[1:0] == 2'h0);
    endfunction : mapped

    tmsc_phase_dec u_phase (
        .clk(clk),
        .sys_rst(sys_rst),
        .inA(extCountInA),
        .inB(extCountInB),
        .step(qStep),
        .down(qDown)
    );

    // apb decode: zero wait states, error on unmapped words
    assign wrEn = psel & penable & pwrite;
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~mapped(paddr);
    assign wrCh = chOf(paddr);
    assign wrCnt = wrEn & isCh(paddr) & (paddr[3:2] == CH_CNT);
    assign syncWrHit = wrCnt & syncQ[wrCh[2:0]];

    // read mux; reserved bits and the undefined bit 7 read as fixed values
    always_comb
    begin
        rdVal = 32'h0000_0000;
        if (isCh(paddr))
        begin
            case (paddr[3:2])
                CH_CNT: rdVal = {16'h0000, cntQ[wrCh[2:0]]};
                CH_CMPA: rdVal = {16'h0000, cmpAQ[wrCh[2:0]]};
                CH_CMPB: rdVal = {16'h0000, cmpBQ[wrCh[2:0]]};
                default: rdVal = 32'h0000_0000;
            endcase
        end
        else
        begin
            case (paddr)
                OFS_SYNC: rdVal = {24'h0, SYNC_FIXED | {3'h0, syncQ}};
                OFS_MODE: rdVal = {24'h0, 1'b0, modeQ};
                OFS_COMBO: rdVal = {30'h0, comboQ};
                OFS_START: rdVal = {27'h0, startQ};
                OFS_STATUS: rdVal = {27'h0, statusQ};
                OFS_IRQEN: rdVal = {27'h0, irqEnQ};
                OFS_CLRA: rdVal = {27'h0, clrAQ};
                OFS_CLRB: rdVal = {27'h0, clrBQ};
                default: rdVal = 32'h0000_0000;
            endcase
        end
    end

    // read data captured in the setup cycle
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= rdVal;
    end

    // control registers, cleared by reset and by standby entry
    always_ff @(posedge clk)
    begin
        if (sys_rst || standbyEnter)
        begin
            syncQ <= SYNC_RST[4:0];
            modeQ <= MODE_RST[6:0];
            comboQ <= COMBO_RST;
            startQ <= 5'h00;
            irqEnQ <= 5'h00;
            clrAQ <= 5'h00;
            clrBQ <= 5'h00;
        end
        else if (wrEn)
        begin
            case (paddr)
                OFS_SYNC: syncQ <= pwdata[4:0];
                OFS_MODE: modeQ <= pwdata[6:0];
                OFS_COMBO: comboQ <= pwdata[1:0];
                OFS_START: startQ <= pwdata[4:0];
                OFS_IRQEN: irqEnQ <= pwdata[4:0];
                OFS_CLRA: clrAQ <= pwdata[4:0];
                OFS_CLRB: clrBQ <= pwdata[4:0];
                default: ;
            endcase
        end
    end

    // per-channel count steps, compare matches and wrap events
    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (i == PHASE_CH && modeQ[PHASE_BIT])
            begin
                stepV[i] = startQ[i] & qStep;
                downV[i] = qDown;
            end
            else
            begin
                stepV[i] = startQ[i];
                downV[i] = 1'b0;
            end
            wrapUpV[i] = stepV[i] & ~downV[i] & (cntQ[i] == CNT_MAX);
            unfV[i] = stepV[i] & downV[i] & (cntQ[i] == CNT_ZERO);
            matchA[i] = cntQ[i] == cmpAQ[i];
            matchB[i] = cntQ[i] == cmpBQ[i];
            clrEv[i] = (clrAQ[i] & matchA[i]) | (clrBQ[i] & matchB[i]);
            flagEv[i] = wrapUpV[i] | (unfV[i]
                & ~(i == PHASE_CH && modeQ[FLAG_DIR_BIT]));
        end
    end

    assign syncClr = |(clrEv & syncQ);

    // counter next values: write, then clear, then count
    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (wrCnt && (wrCh == 4'(i) || (syncWrHit && syncQ[i])))
                cntD[i] = pwdata[15:0];
            else if (clrEv[i] || (syncClr && syncQ[i]))
                cntD[i] = CNT_ZERO;
            else if (stepV[i] && downV[i])
                cntD[i] = cntQ[i] - 16'h0001;
            else if (stepV[i])
                cntD[i] = cntQ[i] + 16'h0001;
            else
                cntD[i] = cntQ[i];
        end
    end

    // counters and compare registers
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (sys_rst || standbyEnter)
            begin
                cntQ[i] <= CNT_ZERO;
                cmpAQ[i] <= CNT_MAX;
                cmpBQ[i] <= CNT_MAX;
            end
            else
            begin
                cntQ[i] <= cntD[i];
                if (wrEn && isCh(paddr) && wrCh == 4'(i))
                begin
                    if (paddr[3:2] == CH_CMPA)
                        cmpAQ[i] <= pwdata[15:0];
                    if (paddr[3:2] == CH_CMPB)
                        cmpBQ[i] <= pwdata[15:0];
                end
            end
        end
    end

    // sticky flags: a new event wins over a same-cycle clear
    always_ff @(posedge clk)
    begin
        if (sys_rst || standbyEnter)
            statusQ <= 5'h00;
        else
            statusQ <= (statusQ & ~((wrEn && paddr == OFS_CLEAR)
                ? pwdata[4:0] : 5'h00)) | flagEv;
    end

    assign irq = |(statusQ & irqEnQ);

    // pwm pins; combination codes 10 and 11 take channels 3 and 4 away
    assign pwmEff = modeQ[4:0]
        & ~{comboQ[COMBO_PWM_BIT], comboQ[COMBO_PWM_BIT], 3'h0};
    // channels whose pin is due to go high at the next edge
    assign pwmSetV = pwmEff & matchA & ~matchB;
    assign ioPinAOut = pinQ;
    assign ioPinAOe = pwmEff;

    always_ff @(posedge clk)
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (sys_rst || standbyEnter || !pwmEff[i])
                pinQ[i] <= 1'b0;
            else if (matchB[i])
                pinQ[i] <= 1'b0;
            else if (matchA[i])
                pinQ[i] <= 1'b1;
        end
    end

    // helper state for checks
    logic [CNT_W-1:0] lastWrQ;
    always_ff @(posedge clk)
    begin
        lastWrQ <= pwdata[15:0];
    end

    chk_sync_write: assert property (@(posedge clk) disable iff (sys_rst)
        wrEn && paddr == OFS_SYNC && !standbyEnter
        |=> syncQ == $past(pwdata[4:0]))
        else $error("sync bits not taken from write");
    chk_reset_values: assert property (@(posedge clk)
        sys_rst |=> syncQ == 5'h00 && modeQ == 7'h00)
        else $error("reset values wrong");
    chk_sync_reserved: assert property (@(posedge clk) disable iff (sys_rst)
        psel && !penable && !pwrite && paddr == OFS_SYNC
        |=> prdata[7:5] == 3'b011)
        else $error("sync reserved bits misread");
    chk_mode_bit7: assert property (@(posedge clk) disable iff (sys_rst)
        psel && !penable && !pwrite && paddr == OFS_MODE
        |=> prdata[7] == 1'b0 && prdata[6:0] == $past(modeQ))
        else $error("mode readback wrong");
    sequence s_phase_up;
        modeQ[PHASE_BIT] && startQ[PHASE_CH] && qStep && !qDown
        && !wrCnt && !clrEv[PHASE_CH] && !syncClr && !standbyEnter;
    endsequence
    chk_phase_up: assert property (@(posedge clk) disable iff (sys_rst)
        s_phase_up |=> cntQ[PHASE_CH] == 16'($past(cntQ[PHASE_CH]) + 1))
        else $error("phase count increment missed");
    chk_phase_hold: assert property (@(posedge clk) disable iff (sys_rst)
        modeQ[PHASE_BIT] && !qStep && !wrCnt && !clrEv[PHASE_CH]
        && !syncClr && !standbyEnter |=> $stable(cntQ[PHASE_CH]))
        else $error("counter 2 moved without a phase edge");
    chk_flag_dir_under: assert property (@(posedge clk) disable iff (sys_rst)
        unfV[PHASE_CH] && !modeQ[FLAG_DIR_BIT] && !standbyEnter
        |=> statusQ[PHASE_CH])
        else $error("underflow flag missing");
    chk_pwm_high: assert property (@(posedge clk) disable iff (sys_rst)
        pwmSetV != 5'h00 && !standbyEnter
        |=> (pinQ & $past(pwmSetV)) == $past(pwmSetV))
        else $error("pwm pin not set on match a");
    chk_combo_mask: assert property (@(posedge clk) disable iff (sys_rst)
        comboQ[COMBO_PWM_BIT] |-> ioPinAOe[4:3] == 2'b00)
        else $error("combination mode did not mask pwm");
    chk_sync_preset: assert property (@(posedge clk) disable iff (sys_rst)
        syncWrHit && !standbyEnter
        |=> cntQ[0] == lastWrQ || !syncQ[0])
        else $error("synchronized preset missed channel 0");
    chk_sync_clear: assert property (@(posedge clk) disable iff (sys_rst)
        syncClr && !wrCnt && !standbyEnter
        |=> cntQ[1] == CNT_ZERO || !syncQ[1])
        else $error("synchronized clear missed channel 1");

endmodule : tmsc_top
`default_nettype wire

// [tb/tmsc_enc_model.sv]
// tmsc_enc_model: quadrature encoder driving the two count pins.
// assumes requests arrive on clk with enough gap for the decoder.
`timescale 1ns/1ps
`default_nettype none
module tmsc_enc_model (
    input wire logic clk,       // bench clock
    input wire logic stepReq,   // advance one quadrature phase
    input wire logic stepDown,  // 1 = reverse direction
    output logic encA,          // ext_count_in_a level
    output logic encB           // ext_count_in_b level
);
    logic [1:0] phaseQ = 2'h0;
    // phase walk 00,01,11,10 counts up; the reverse counts down
    always_ff @(posedge clk)
    begin
        if (stepReq)
        begin
            phaseQ <= stepDown ? phaseQ - 2'h1 : phaseQ + 2'h1;
        end
    end
    // gray decode: one pin changes per step, never both
    assign encA = phaseQ[1];
    assign encB = phaseQ[1] ^ phaseQ[0];
endmodule : tmsc_enc_model
`default_nettype wire

// [tb/timer_sync_and_mode_control_tb_top.sv]
// timer_sync_and_mode_control_tb_top: self-checking bench for tmsc_top.
// assumes the tmsc_pkg register map and a zero-wait APB slave.
`timescale 1ns/1ps
`default_nettype none
module timer_sync_and_mode_control_tb_top;
    import tmsc_pkg::*;
    logic clk, sysRst, standbyEnter, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic encA, encB, irq, stepReq, stepDown;
    logic [4:0] pinOut, pinOe;
    int bad_count = 0;
    int compares = 0;
    // design and far-side encoder
    tmsc_top dut_u (.clk(clk), .sys_rst(sysRst), .standbyEnter(standbyEnter),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .extCountInA(encA), .extCountInB(encB),
        .ioPinAOut(pinOut), .ioPinAOe(pinOe), .irq(irq));
    tmsc_enc_model enc_u (.clk(clk), .stepReq(stepReq),
        .stepDown(stepDown), .encA(encA), .encB(encB));
    // 250 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic end_sim;
        if (bad_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chkWord
    task automatic chkBit(input logic got, input logic exp);
        chkWord({31'h0, got}, {31'h0, exp});
    endtask : chkBit
    function automatic logic [7:0] chAddr(input int ch, input logic [1:0] w);
        return OFS_CH_BASE + 8'(16 * ch) + {4'h0, w, 2'h0};
    endfunction : chAddr
    // one APB transfer, held until pready is sampled high
    task automatic apbXfer(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apbXfer
    task automatic regWr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apbXfer(1'b1, a, d, rd, err);
    endtask : regWr
    task automatic regCheck(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apbXfer(1'b0, a, 32'h0, rd, err);
        chkWord(rd, exp);
    endtask : regCheck
    // quadrature steps spaced for the input synchroniser
    task automatic encStep(input logic down, input int n);
        repeat (n)
        begin
            @(posedge clk);
            stepReq <= 1'b1;
            stepDown <= down;
            @(posedge clk);
            stepReq <= 1'b0;
            repeat (6) @(posedge clk);
        end
    endtask : encStep
    task automatic tRegs;
        logic [31:0] rd;
        logic err;
        regCheck(OFS_SYNC, 32'h60);
        regCheck(OFS_MODE, 32'h00);
        regCheck(chAddr(0, CH_CMPA), 32'hFFFF);
        regWr(OFS_SYNC, 32'hFF);
        regCheck(OFS_SYNC, 32'h7F);
        regWr(OFS_MODE, 32'hFF);
        regCheck(OFS_MODE, 32'h7F);
        apbXfer(1'b1, 8'h3C, 32'h1, rd, err);
        chkBit(err, 1'b1);
        regWr(OFS_STATUS, 32'h1F);
        regCheck(OFS_STATUS, 32'h0);
        @(posedge clk);
        standbyEnter <= 1'b1;
        repeat (2) @(posedge clk);
        standbyEnter <= 1'b0;
        regCheck(OFS_SYNC, 32'h60);
        regCheck(OFS_MODE, 32'h00);
    endtask : tRegs
    task automatic tSync;
        regWr(OFS_SYNC, 32'h73);
        regWr(chAddr(1, CH_CNT), 32'h1234);
        for (int c = 0; c < 5; c++)
            regCheck(chAddr(c, CH_CNT), c inside {0, 1, 4} ? 32'h1234 : 0);
        regWr(OFS_SYNC, 32'h60);
        regWr(chAddr(1, CH_CNT), 32'h55);
        regCheck(chAddr(0, CH_CNT), 32'h1234);
        // clear on match a in channel 0 also clears synced channel 1
        regWr(OFS_SYNC, 32'h63);
        regWr(chAddr(0, CH_CMPA), 32'h1234);
        regWr(OFS_CLRA, 32'h01);
        regCheck(chAddr(1, CH_CNT), 32'h0);
        regCheck(chAddr(4, CH_CNT), 32'h1234);
        regWr(OFS_CLRA, 32'h00);
        regWr(OFS_SYNC, 32'h60);
    endtask : tSync
    task automatic tPhase;
        regWr(OFS_MODE, 32'h40);
        regWr(OFS_IRQEN, 32'h04);
        regWr(OFS_START, 32'h04);
        encStep(1'b1, 4);
        regCheck(chAddr(2, CH_CNT), 32'hFFFC);
        regCheck(OFS_STATUS, 32'h04);
        chkBit(irq, 1'b1);
        regWr(OFS_CLEAR, 32'h04);
        regCheck(OFS_STATUS, 32'h00);
        chkBit(irq, 1'b0);
        encStep(1'b0, 8);
        regCheck(chAddr(2, CH_CNT), 32'h0004);
        regCheck(OFS_STATUS, 32'h04);
        regWr(OFS_CLEAR, 32'h04);
        regWr(OFS_MODE, 32'h60);
        encStep(1'b1, 8);
        regCheck(chAddr(2, CH_CNT), 32'hFFFC);
        regCheck(OFS_STATUS, 32'h00);
        encStep(1'b0, 4);
        regCheck(OFS_STATUS, 32'h04);
        regWr(OFS_IRQEN, 32'h00);
        @(negedge clk);
        chkBit(irq, 1'b0);
        regWr(OFS_START, 32'h00);
        regWr(OFS_MODE, 32'h00);
    endtask : tPhase
    task automatic tPwm;
        int high;
        regWr(chAddr(0, CH_CMPA), 32'h5);
        regWr(chAddr(0, CH_CMPB), 32'h9);
        regWr(OFS_CLRB, 32'h01);
        regWr(chAddr(0, CH_CNT), 32'h0);
        regWr(OFS_MODE, 32'h19);
        regWr(OFS_START, 32'h01);
        repeat (20) @(posedge clk);
        high = 0;
        repeat (40)
        begin
            @(negedge clk);
            high += int'(pinOut[0] === 1'b1);
        end
        chkWord(32'(high), 32'd16);
        chkBit(pinOe[0], 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            regWr(OFS_COMBO, 32'(k));
            @(negedge clk);
            chkBit(pinOe[3], k < 2);
            chkBit(pinOe[4], k < 2);
        end
    endtask : tPwm
    // reset, scenarios, verdict
    initial
    begin
        sysRst = 1'b1;
        standbyEnter = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        stepReq = 1'b0;
        stepDown = 1'b0;
        repeat (8) @(posedge clk);
        sysRst <= 1'b0;
        repeat (4) @(posedge clk);
        chkBit(irq, 1'b0);
        tRegs();
        tSync();
        tPhase();
        tPwm();
        end_sim();
    end
    // watchdog against a hung handshake
    initial
    begin
        #80000;
        bad_count++;
        end_sim();
    end
endmodule : timer_sync_and_mode_control_tb_top
`default_nettype wire
